/* gsp_status_poll.v */
// Status change flags, parallel poll configuration and source/acceptor status
//
// Notes on behaviour
// - Command-out-empty clears on uninhibited status read, leaving active/generate, or byte taken.
// - Lockout-change flag, status bit 2, sets on any lockout state change.
// - Lockout-change clears on reset, uninhibited status read, or its clear command.
// - Bus-control-change flag, status bit 1, sets on any bus-controlled change.
// - Bus-control-change clears on reset, uninhibited status read, or its clear command.
// - Address-change flag, bit 0, sets on address bit change unless listen/talk-only.
// - Address-change clears on reset, uninhibited read, clear command, or listen/talk-only.
// - Aux mode write with top bits 011 stores low five bits as poll config.
// - Remote poll configuration applies itself; host must not write local config then.
// - Lock bit 0 lets received enable/disable overwrite config; 1 keeps local.
// - Unconfigure bit 4 set keeps out of polls; clear responds per fields.
// - Host poll config write sets all five bits, lock bit or not, and wins over a received enable/disable.
// - During poll, selected line asserted when sense bit equals status message.
// - Line-select 000 picks line 1 up to 111 picking line 8.
// - Source/acceptor status bits 7..0: nba, holdoffs, ready, source state bits.
// - Acceptor idle decoded from ATN and listener address; not-ready and ready from ready and DAV.
// - Acceptor data-accepted when ready with DAV, or held off under ATN.
// - Acceptor wait-new-cycle when not ready with DAV, except ATN holdoff.
// - Status register read clears event flags only while clear inhibit is 0.
`timescale 1ns/10ps
`include "gsp_consts.vh"

module gsp_status_poll (
    input  wire       clk,
    input  wire       arst_n,
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       cacs,
    input  wire       sgns,
    input  wire       nba,
    input  wire       cmd_taken,
    input  wire       lockout_state,
    input  wire       bus_controlled_flag,
    input  wire       addressed_to_send,
    input  wire       addressed_to_receive,
    input  wire       cic,
    input  wire       major_minor_select,
    input  wire       atn,
    input  wire       dav,
    input  wire       rx_ppe,
    input  wire       rx_ppd,
    input  wire [3:0] rx_pp_bits,
    input  wire       pp_active,
    input  wire       end_holdoff_state,
    input  wire       notready_holdoff,
    input  wire       notready_holdoff_now,
    input  wire       data_holdoff_state,
    input  wire       acceptor_ready,
    input  wire       source_state_hi,
    input  wire       source_state_lo,
    output reg  [7:0] pp_line_out,
    output reg  [7:0] pp_line_oe
);

    // Reset release synchroniser
    reg        rst_meta;
    reg        rst_n;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Control register and stored state
    reg  [3:0] ctrl;
    reg  [4:0] poll_cfg;
    reg        ist;
    reg        cmd_out_empty;
    reg        lockout_change;
    reg        bus_control_change;
    reg        address_state_change;
    reg        primed;
    reg        prev_lock;
    reg        prev_remote;
    reg  [3:0] prev_adr;

    wire       status_clear_inhibit;
    wire       local_poll_lock;
    wire       listen_only;
    wire       talk_only;
    wire       lon_ton;
    wire       wr_aux;
    wire       wr_ctrl;
    wire       wr_poll_cfg;
    wire       rd_isr2;
    wire       rd_clear;
    wire       aux_clr_lock;
    wire       aux_clr_remote;
    wire       aux_clr_addr;
    wire       aux_set_ist;
    wire       aux_clr_ist;
    wire       set_cmd_empty;
    wire       clr_cmd_empty;
    wire       lok_edge;
    wire       rem_edge;
    wire       adr_edge;
    wire [3:0] cur_adr;
    wire       remote_apply;
    wire [7:0] isr2_value;
    wire [7:0] srcacc_value;
    wire [4:0] acc_state;
    wire       acc_idle;
    wire       acc_not_ready;
    wire       acc_ready;
    wire       acc_accepted;
    wire       acc_wait_new;
    wire       respond;
    wire [7:0] line_sel;

    assign status_clear_inhibit = ctrl[`GSP_CTRL_CLR_INH];
    assign local_poll_lock      = ctrl[`GSP_CTRL_PPLOCK];
    assign listen_only          = ctrl[`GSP_CTRL_LON];
    assign talk_only            = ctrl[`GSP_CTRL_TON];
    assign lon_ton              = listen_only | talk_only;

    // Host port decode
    assign wr_aux  = reg_wr & (reg_addr == `GSP_OFF_AUX);
    assign wr_ctrl = reg_wr & (reg_addr == `GSP_OFF_CTRL);
    assign wr_poll_cfg = wr_aux & (reg_wdata[7:5] == `GSP_POLL_PATTERN);
    assign rd_isr2 = reg_rd & (reg_addr == `GSP_OFF_ISR2);
    assign rd_clear = rd_isr2 & ~status_clear_inhibit;

    assign aux_clr_lock   = wr_aux & (reg_wdata == `GSP_AUX_CLR_LOCK);
    assign aux_clr_remote = wr_aux & (reg_wdata == `GSP_AUX_CLR_REMOTE);
    assign aux_clr_addr   = wr_aux & (reg_wdata == `GSP_AUX_CLR_ADDR);
    assign aux_set_ist  = wr_aux & (reg_wdata == `GSP_AUX_SET_IST);
    assign aux_clr_ist  = wr_aux & (reg_wdata == `GSP_AUX_CLR_IST);

    // Command-out-empty set and clear terms
    assign set_cmd_empty = cacs & sgns & ~nba;
    assign clr_cmd_empty = rd_clear | ~cacs | ~sgns | cmd_taken;

    // Change detection against last cycle
    assign cur_adr  = {major_minor_select, cic, addressed_to_receive, addressed_to_send};
    assign lok_edge = primed & (lockout_state != prev_lock);
    assign rem_edge = primed & (bus_controlled_flag != prev_remote);
    assign adr_edge = primed & (cur_adr != prev_adr);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            primed   <= 1'b0;
            prev_lock   <= 1'b0;
            prev_remote <= 1'b0;
            prev_adr <= 4'h0;
        end else begin
            primed   <= 1'b1;
            prev_lock   <= lockout_state;
            prev_remote <= bus_controlled_flag;
            prev_adr <= cur_adr;
        end
    end

    // Event flags; a set in the clearing cycle wins, except listen/talk-only clearing address-change
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_out_empty        <= 1'b0;
            lockout_change       <= 1'b0;
            bus_control_change   <= 1'b0;
            address_state_change <= 1'b0;
        end else begin
            cmd_out_empty      <= set_cmd_empty | (cmd_out_empty & ~clr_cmd_empty);
            lockout_change     <= lok_edge | (lockout_change & ~(rd_clear | aux_clr_lock));
            bus_control_change <= rem_edge
                                | (bus_control_change & ~(rd_clear | aux_clr_remote));
            if (lon_ton) begin
                address_state_change <= 1'b0;
            end else begin
                address_state_change <= adr_edge
                                      | (address_state_change & ~(rd_clear | aux_clr_addr));
            end
        end
    end

    // Control register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `GSP_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata[3:0];
        end
    end

    // Individual status message, kept by host commands
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ist <= 1'b0;
        end else if (aux_set_ist) begin
            ist <= 1'b1;
        end else if (aux_clr_ist) begin
            ist <= 1'b0;
        end
    end

    // Poll configuration: host write sets all five bits and wins over a received message
    assign remote_apply = ~local_poll_lock & (rx_ppe | rx_ppd);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_cfg <= `GSP_POLL_RESET;
        end else if (wr_poll_cfg) begin
            poll_cfg <= reg_wdata[4:0];
        end else if (remote_apply) begin
            if (rx_ppe) begin
                poll_cfg <= {1'b0, rx_pp_bits};
            end else begin
                poll_cfg <= `GSP_POLL_RESET;
            end
        end
    end

    // Poll response on the selected line, open drain
    assign respond = pp_active & ~poll_cfg[`GSP_POLL_BIT_U]
                   & (poll_cfg[`GSP_POLL_BIT_S] == ist);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_line
            localparam [2:0] LINE_CODE = gi;
            assign line_sel[gi] = (poll_cfg[2:0] == LINE_CODE);
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pp_line_out <= 8'h00;
            pp_line_oe  <= 8'h00;
        end else begin
            pp_line_out <= 8'h00;
            pp_line_oe  <= respond ? line_sel : 8'h00;
        end
    end

    // Acceptor state decode
    gsp_acceptor u_acceptor (
        .atn                  (atn),
        .addressed_to_receive (addressed_to_receive),
        .acceptor_ready       (acceptor_ready),
        .dav                  (dav),
        .data_holdoff_state   (data_holdoff_state),
        .acc_idle             (acc_idle),
        .acc_not_ready        (acc_not_ready),
        .acc_ready            (acc_ready),
        .acc_accepted         (acc_accepted),
        .acc_wait_new         (acc_wait_new)
    );

    assign acc_state = {acc_wait_new, acc_accepted, acc_ready, acc_not_ready, acc_idle};

    // Read values
    assign isr2_value = {1'b0, 1'b0, lockout_state, bus_controlled_flag, cmd_out_empty,
                         lockout_change, bus_control_change, address_state_change};
    assign srcacc_value = {nba, end_holdoff_state, notready_holdoff, notready_holdoff_now,
                         data_holdoff_state, acceptor_ready, source_state_hi, source_state_lo};

    // Read data valid only in the cycle after the strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `GSP_OFF_ISR2: begin
                    reg_rdata <= isr2_value;
                end
                `GSP_OFF_SRCACC: begin
                    reg_rdata <= srcacc_value;
                end
                `GSP_OFF_PPSTAT: begin
                    reg_rdata <= {2'h0, ist, poll_cfg};
                end
                `GSP_OFF_CTRL: begin
                    reg_rdata <= {4'h0, ctrl};
                end
                `GSP_OFF_ACCSTAT: begin
                    reg_rdata <= {3'h0, acc_state};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

/* gsp_consts.vh */
// Offsets, field positions and reset values of the status and parallel-poll block
`ifndef GSP_CONSTS_VH
`define GSP_CONSTS_VH

// Register offsets on the host port
`define GSP_OFF_ISR2      3'h1
`define GSP_OFF_SRCACC    3'h3
`define GSP_OFF_PPSTAT    3'h4
`define GSP_OFF_AUX       3'h5
`define GSP_OFF_CTRL      3'h6
`define GSP_OFF_ACCSTAT   3'h7

// Status register bit positions
`define GSP_BIT_ADDR_CHG   0
`define GSP_BIT_REMOTE_CHG 1
`define GSP_BIT_LOCK_CHG   2
`define GSP_BIT_CMD_EMPTY  3
`define GSP_BIT_REMOTE     4
`define GSP_BIT_LOCK       5

// Poll configuration write: pattern in data bits 7..5
`define GSP_POLL_PATTERN  3'h3
`define GSP_POLL_BIT_U    4
`define GSP_POLL_BIT_S    3
`define GSP_POLL_RESET    5'h10

// Auxiliary commands (upper bits 000)
`define GSP_AUX_CLR_LOCK   8'h01
`define GSP_AUX_CLR_REMOTE 8'h02
`define GSP_AUX_CLR_ADDR   8'h03
`define GSP_AUX_SET_IST   8'h04
`define GSP_AUX_CLR_IST   8'h05

// Control register bit positions
`define GSP_CTRL_CLR_INH  0
`define GSP_CTRL_PPLOCK   1
`define GSP_CTRL_LON      2
`define GSP_CTRL_TON      3
`define GSP_CTRL_RESET    4'h0

`endif

/* gsp_acceptor.v */
// Acceptor handshake state decode from ready, data-valid, attention and holdoff
`timescale 1ns/10ps

module gsp_acceptor (
    input  wire atn,
    input  wire addressed_to_receive,
    input  wire acceptor_ready,
    input  wire dav,
    input  wire data_holdoff_state,
    output wire acc_idle,
    output wire acc_not_ready,
    output wire acc_ready,
    output wire acc_accepted,
    output wire acc_wait_new
);

    wire atn_hold;

    assign atn_hold      = atn & data_holdoff_state;
    assign acc_idle      = ~atn & ~addressed_to_receive;
    assign acc_not_ready = ~acc_idle & ~acceptor_ready & ~dav;
    assign acc_ready     = ~acc_idle & acceptor_ready & ~dav;
    assign acc_accepted  = (~acc_idle & acceptor_ready & dav)
                         | (~acc_idle & ~acceptor_ready & dav & atn_hold);
    assign acc_wait_new  = ~acc_idle & ~acceptor_ready & dav & ~atn_hold;

endmodule

/* gsp_status_poll_asserts.sv */
// Port-level checks for the status and parallel poll block
`timescale 1ns/10ps
`include "gsp_consts.vh"

module gsp_sp_checker (
    input wire       clk,
    input wire       arst_n,
    input wire [2:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       lockout_state,
    input wire       bus_controlled_flag,
    input wire       atn,
    input wire       dav,
    input wire       addressed_to_receive,
    input wire       data_holdoff_state,
    input wire       acceptor_ready,
    input wire       pp_active,
    input wire [7:0] pp_line_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    wire       acc_rd = reg_rd && (reg_addr == `GSP_OFF_ACCSTAT);
    wire       idle   = !atn && !addressed_to_receive;
    wire       hold   = atn && data_holdoff_state;
    wire [4:0] acc_now = {!idle && !acceptor_ready && dav && !hold,
                          !idle && dav && (acceptor_ready || hold),
                          !idle && acceptor_ready && !dav,
                          !idle && !acceptor_ready && !dav, idle};

    sequence quiet_bus;
        !reg_rd && !reg_wr;
    endsequence
    sequence status_read;
        reg_rd && (reg_addr == `GSP_OFF_ISR2);
    endsequence

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    acc_rest_a: assert property (acc_rd |=> reg_rdata[2:0] == $past(acc_now[2:0]))
        else $error("acceptor idle or ready state wrong");
    acc_done_a: assert property (acc_rd |=> reg_rdata[3] == $past(acc_now[3]))
        else $error("acceptor accepted state wrong");
    acc_wait_a: assert property (acc_rd |=> reg_rdata[4] == $past(acc_now[4]))
        else $error("acceptor wait state wrong");
    lock_change_a: assert property ($changed(lockout_state) ##0 quiet_bus ##1 status_read |=> reg_rdata[2])
        else $error("lockout change flag missing");
    remote_change_a: assert property ($changed(bus_controlled_flag) ##0 quiet_bus ##1 status_read |=> reg_rdata[1])
        else $error("remote change flag missing");
    poll_quiet_a: assert property (!$past(pp_active) |-> pp_line_oe == 8'h00)
        else $error("poll line driven outside poll");
    poll_onehot_a: assert property ($onehot0(pp_line_oe))
        else $error("more than one poll line driven");
endmodule

bind gsp_status_poll gsp_sp_checker chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lockout_state(lockout_state), .bus_controlled_flag(bus_controlled_flag),
    .atn(atn), .dav(dav), .addressed_to_receive(addressed_to_receive), .data_holdoff_state(data_holdoff_state),
    .acceptor_ready(acceptor_ready), .pp_active(pp_active), .pp_line_oe(pp_line_oe));

/* gsp_bus_model.sv */
// Bus controller model: poll messages and pulled-up data lines
`timescale 1ns/10ps

module gsp_bus_model (
    input  wire       clk,
    input  wire [7:0] pp_line_out,
    input  wire [7:0] pp_line_oe,
    output reg        rx_ppe,
    output reg        rx_ppd,
    output reg  [3:0] rx_pp_bits,
    output reg        pp_active,
    output wire [7:0] dio_n
);
    // Pulled high, low only where the device drives
    assign dio_n = ~pp_line_oe | pp_line_out;

    initial begin
        rx_ppe = 1'b0;
        rx_ppd = 1'b0;
        rx_pp_bits = 4'h0;
        pp_active = 1'b0;
    end

    task ppe(input [3:0] bits);
        begin
            @(posedge clk);
            rx_ppe <= 1'b1;
            rx_pp_bits <= bits;
            @(posedge clk);
            rx_ppe <= 1'b0;
            rx_pp_bits <= ~bits;
        end
    endtask

    task ppd;
        begin
            @(posedge clk);
            rx_ppd <= 1'b1;
            @(posedge clk);
            rx_ppd <= 1'b0;
        end
    endtask

    task poll(input on);
        begin
            @(posedge clk);
            pp_active <= on;
        end
    endtask
endmodule

/* gsp_status_poll_test.sv */
// Self-checking bench for the status and parallel poll block
`timescale 1ns/10ps
`include "gsp_consts.vh"

module gsp_status_poll_test;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg  [2:0]  reg_addr = 3'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [10:0] lv = 11'h000;
    reg  [7:0]  hs = 8'h00;
    reg         a, l, r, d, h, idl;
    wire [7:0]  reg_rdata, pp_line_out, pp_line_oe, dio_n;
    wire [3:0]  rx_pp_bits;
    wire        rx_ppe, rx_ppd, pp_active;
    integer     mismatches = 0;
    integer     num_checks = 0;
    integer     i;

    always #2 clk = ~clk;

    gsp_status_poll dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cacs(lv[0]), .sgns(lv[1]), .nba(hs[7]), .cmd_taken(lv[2]),
        .lockout_state(lv[3]), .bus_controlled_flag(lv[4]), .addressed_to_send(lv[5]),
        .addressed_to_receive(lv[6]), .cic(lv[7]), .major_minor_select(lv[8]), .atn(lv[9]), .dav(lv[10]),
        .rx_ppe(rx_ppe), .rx_ppd(rx_ppd), .rx_pp_bits(rx_pp_bits), .pp_active(pp_active),
        .end_holdoff_state(hs[6]), .notready_holdoff(hs[5]), .notready_holdoff_now(hs[4]),
        .data_holdoff_state(hs[3]), .acceptor_ready(hs[2]), .source_state_hi(hs[1]), .source_state_lo(hs[0]),
        .pp_line_out(pp_line_out), .pp_line_oe(pp_line_oe));

    gsp_bus_model bus (.clk(clk), .pp_line_out(pp_line_out), .pp_line_oe(pp_line_oe), .rx_ppe(rx_ppe),
        .rx_ppd(rx_ppd), .rx_pp_bits(rx_pp_bits), .pp_active(pp_active), .dio_n(dio_n));

    task check(input [8*20-1:0] name, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    task wr(input [2:0] adr, input [7:0] dat);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= adr;
            reg_wdata <= dat;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask

    task rd(input [2:0] adr, input [7:0] exp, input [8*20-1:0] name);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= adr;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            check(name, exp, reg_rdata);
        end
    endtask

    task line(input [7:0] exp);
        begin
            repeat (2) @(posedge clk);
            #1;
            check("poll enable", exp, pp_line_oe);
            check("data lines", ~exp, dio_n);
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    initial begin
        #40000;
        mismatches = mismatches + 1;
        end_sim;
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`GSP_OFF_CTRL, 8'h00, "ctrl reset");
        rd(`GSP_OFF_PPSTAT, 8'h10, "poll reset");
        rd(3'h0, 8'h00, "unmapped");
        @(posedge clk) hs <= 8'hA5;
        rd(`GSP_OFF_SRCACC, 8'hA5, "source acceptor");
        $display("test map done");
        @(posedge clk) lv[3] <= 1'b1;
        rd(`GSP_OFF_ISR2, 8'h24, "lockout set");
        rd(`GSP_OFF_ISR2, 8'h20, "lockout read clr");
        wr(`GSP_OFF_CTRL, 8'h01);
        @(posedge clk) lv[3] <= 1'b0;
        rd(`GSP_OFF_ISR2, 8'h04, "lockout inhibit");
        rd(`GSP_OFF_ISR2, 8'h04, "lockout kept");
        wr(`GSP_OFF_AUX, `GSP_AUX_CLR_LOCK);
        rd(`GSP_OFF_ISR2, 8'h00, "lockout cmd clr");
        @(posedge clk) lv[4] <= 1'b1;
        rd(`GSP_OFF_ISR2, 8'h12, "remote set");
        wr(`GSP_OFF_AUX, `GSP_AUX_CLR_REMOTE);
        rd(`GSP_OFF_ISR2, 8'h10, "remote cmd clr");
        @(posedge clk) lv[7] <= 1'b1;
        rd(`GSP_OFF_ISR2, 8'h11, "address set");
        wr(`GSP_OFF_AUX, `GSP_AUX_CLR_ADDR);
        rd(`GSP_OFF_ISR2, 8'h10, "address cmd clr");
        @(posedge clk) lv[8] <= 1'b1;
        wr(`GSP_OFF_CTRL, 8'h05);
        rd(`GSP_OFF_ISR2, 8'h10, "address lon clr");
        @(posedge clk) lv[5] <= 1'b1;
        wr(`GSP_OFF_CTRL, 8'h09);
        rd(`GSP_OFF_ISR2, 8'h10, "address ton");
        wr(`GSP_OFF_CTRL, 8'h00);
        $display("test flags done");
        @(posedge clk) {hs[7], lv[1:0]} <= 3'b011;
        rd(`GSP_OFF_ISR2, 8'h18, "cmd empty set");
        @(posedge clk) hs[7] <= 1'b1;
        rd(`GSP_OFF_ISR2, 8'h18, "cmd empty held");
        rd(`GSP_OFF_ISR2, 8'h10, "cmd empty rd clr");
        @(posedge clk) hs[7] <= 1'b0;
        @(posedge clk) {hs[7], lv[2]} <= 2'b11;
        rd(`GSP_OFF_ISR2, 8'h10, "cmd empty taken");
        @(posedge clk) lv[2:0] <= 3'b000;
        $display("test command done");
        wr(`GSP_OFF_AUX, 8'h6A);
        wr(`GSP_OFF_AUX, `GSP_AUX_SET_IST);
        bus.poll(1'b1);
        line(8'h04);
        wr(`GSP_OFF_AUX, `GSP_AUX_CLR_IST);
        line(8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            wr(`GSP_OFF_AUX, {5'b01100, i[2:0]});
            line(8'h01 << i);
        end
        wr(`GSP_OFF_AUX, 8'h70);
        line(8'h00);
        rd(`GSP_OFF_PPSTAT, 8'h10, "unconfigured");
        bus.poll(1'b0);
        bus.ppe(4'hB);
        rd(`GSP_OFF_PPSTAT, 8'h0B, "remote enable");
        bus.ppd;
        rd(`GSP_OFF_PPSTAT, 8'h10, "remote disable");
        wr(`GSP_OFF_AUX, 8'h65);
        wr(`GSP_OFF_CTRL, 8'h02);
        bus.ppe(4'hB);
        rd(`GSP_OFF_PPSTAT, 8'h05, "locked enable");
        bus.ppd;
        rd(`GSP_OFF_PPSTAT, 8'h05, "locked disable");
        $display("test poll done");
        for (i = 0; i < 32; i = i + 1) begin
            {a, l, r, d, h} = i[4:0];
            @(posedge clk) {lv[9], lv[6], hs[2], lv[10], hs[3]} <= i[4:0];
            idl = !a && !l;
            rd(`GSP_OFF_ACCSTAT, {3'b000, !idl && !r && d && !(a && h), !idl && d && (r || a && h),
                !idl && r && !d, !idl && !r && !d, idl}, "acceptor state");
        end
        $display("test acceptor done");
        end_sim;
    end
endmodule
